// [core/rtcca_top.sv]
// rtc calibration and alarm block with axi4-lite register slave
`timescale 1ns/1ps
`include "rtcca_cfg.svh"
module rtcca_top import rtcca_pkg::*; #(
  parameter int unsigned TICK_CYC = `RC_TICK_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_axil_awaddr_i,
  input wire logic s_axil_awvalid_i,
  output logic s_axil_awready_o,
  input wire logic [31:0] s_axil_wdata_i,
  input wire logic [3:0] s_axil_wstrb_i,
  input wire logic s_axil_wvalid_i,
  output logic s_axil_wready_o,
  output logic [1:0] s_axil_bresp_o,
  output logic s_axil_bvalid_o,
  input wire logic s_axil_bready_i,
  input wire logic [7:0] s_axil_araddr_i,
  input wire logic s_axil_arvalid_i,
  output logic s_axil_arready_o,
  output logic [31:0] s_axil_rdata_o,
  output logic [1:0] s_axil_rresp_o,
  output logic s_axil_rvalid_o,
  input wire logic s_axil_rready_i,
  input wire logic [47:0] time_now_i,
  output logic irq_o,
  output logic alarm_pulse_o,
  output logic pwc_ctl_o,
  output logic pwc_sample_o
);
  localparam rtcca_top_s TOP_RST = '{pwin: `RC_PWIN_RST, pwc_pol: 1'b1, default: '0};

  rtcca_top_s st_ff;
  rtcca_top_s nxt_st;
  logic wr_do;
  logic [31:0] w_word;
  logic [1:0] stat_clr;
  logic [1:0] stat_set;
  logic al_ev;

  rtcca_link_if lnk ();

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // register view, shared by reads and by byte-merged writes
  function automatic logic [31:0] reg_word(input rtcca_top_s s, input logic [7:0] a,
                                          input logic sync);
    case (a)
      `RC_OFF_CTRL: reg_word = {28'h0, s.pwc_pol, s.pwc_en, s.run, s.unlock};
      `RC_OFF_CAL: reg_word = {24'h0, s.cal};
      `RC_OFF_ALCFG: reg_word = {16'h0, s.al_on, s.endless, s.alarm_digit_mask, 2'h0, s.rpt};
      `RC_OFF_ALV_LO: reg_word = {8'h0, s.alv_lo};
      `RC_OFF_ALV_HI: reg_word = {8'h0, s.alv_hi};
      `RC_OFF_PWIN: reg_word = {24'h0, s.pwin};
      `RC_OFF_STAT: reg_word = {30'h0, s.stat};
      `RC_OFF_IMSK: reg_word = {30'h0, s.imsk};
      `RC_OFF_STATE: reg_word = {29'h0, s.pwc_busy, s.pulse, sync};
      default: reg_word = 32'h0;
    endcase
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = a[1:0] == 2'h0 && a <= `RC_OFF_STATE;
  endfunction

  // byte lanes not strobed keep their old value
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                       input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? d[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // sub blocks
  rtcca_timebase #(
    .TICK_CYC(TICK_CYC)
  ) u_timebase (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .lnk(lnk.tb)
  );

  rtcca_match u_match (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .lnk(lnk.am)
  );

  // calendar digits come from same-clock logic, so no synchroniser
  assign lnk.run = st_ff.run;
  assign lnk.cal = st_ff.cal;
  assign lnk.now = time_now_i;
  assign lnk.alv = {st_ff.alv_hi, st_ff.alv_lo};
  assign lnk.alarm_digit_mask = st_ff.alarm_digit_mask;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sample = 1'b0;
    // write channels are taken independently, in either order
    if (s_axil_awvalid_i && st_ff.awrdy) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.aw_addr = s_axil_awaddr_i;
    end
    if (s_axil_wvalid_i && st_ff.wrdy) begin
      nxt_st.w_have = 1'b1;
      nxt_st.w_data = s_axil_wdata_i;
      nxt_st.w_strb = s_axil_wstrb_i;
    end
    if (st_ff.bvalid && s_axil_bready_i) begin
      nxt_st.bvalid = 1'b0;
    end
    wr_do = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
    w_word = merge(reg_word(st_ff, st_ff.aw_addr, lnk.sync), st_ff.w_data,
                   st_ff.w_strb);
    stat_clr = 2'h0;
    if (wr_do) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = addr_ok(st_ff.aw_addr) ? `RC_RESP_OK : `RC_RESP_ERR;
      case (st_ff.aw_addr)
        `RC_OFF_CTRL: begin
          nxt_st.unlock = w_word[0];
          nxt_st.run = w_word[1];
          nxt_st.pwc_en = w_word[2];
          nxt_st.pwc_pol = w_word[3];
        end
        `RC_OFF_CAL: nxt_st.cal = w_word[7:0];
        `RC_OFF_ALCFG: begin
          nxt_st.al_on = w_word[`RC_AL_ON];
          nxt_st.endless = w_word[`RC_AL_ENDLESS];
          nxt_st.alarm_digit_mask = w_word[`RC_AL_MASK_HI:`RC_AL_MASK_LO];
          nxt_st.rpt = w_word[7:0];
        end
        `RC_OFF_ALV_LO: nxt_st.alv_lo = w_word[23:0];
        `RC_OFF_ALV_HI: nxt_st.alv_hi = w_word[23:0];
        `RC_OFF_PWIN: begin
          if (st_ff.unlock) begin
            nxt_st.pwin = w_word[7:0];
          end
        end
        // write-one-to-clear; only lane 0 strobes count
        `RC_OFF_STAT: stat_clr = st_ff.w_data[1:0] & {2{st_ff.w_strb[0]}};
        `RC_OFF_IMSK: nxt_st.imsk = w_word[1:0];
        default: ;
      endcase
    end
    nxt_st.awrdy = !nxt_st.aw_have && !nxt_st.bvalid;
    nxt_st.wrdy = !nxt_st.w_have && !nxt_st.bvalid;
    // read: one at a time, answered the cycle after the address is taken
    if (st_ff.rvalid && s_axil_rready_i) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axil_arvalid_i && st_ff.arrdy) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = reg_word(st_ff, s_axil_araddr_i, lnk.sync);
      nxt_st.rresp = addr_ok(s_axil_araddr_i) ? `RC_RESP_OK : `RC_RESP_ERR;
    end
    nxt_st.arrdy = !nxt_st.rvalid;

    // alarm sequencing; an event overrides a same-cycle software write of al_on, and of rpt while repeats remain or endless is set
    al_ev = lnk.ev && st_ff.al_on;
    stat_set = 2'h0;
    if (al_ev) begin
      stat_set[0] = 1'b1;
      nxt_st.pulse = ~st_ff.pulse;
      if (st_ff.rpt != 8'h0) begin
        nxt_st.rpt = st_ff.rpt - 8'h1;
        nxt_st.al_on = 1'b1;
      end else if (st_ff.endless) begin
        nxt_st.rpt = `RC_RPT_WRAP;
        nxt_st.al_on = 1'b1;
      end else begin
        nxt_st.al_on = 1'b0;
      end
    end

    // power control: on at an alarm, stable after the window of ticks
    if (st_ff.pwc_busy) begin
      if (st_ff.pwc_cnt == st_ff.pwin) begin
        nxt_st.pwc_busy = 1'b0;
        nxt_st.sample = 1'b1;
        stat_set[1] = 1'b1;
      end else if (lnk.tick) begin
        nxt_st.pwc_cnt = st_ff.pwc_cnt + 8'h1;
      end
    end else if (al_ev && st_ff.pwc_en) begin
      // an alarm starts it only while idle, so endless repeat makes this periodic
      nxt_st.pwc_busy = 1'b1;
      nxt_st.pwc_cnt = 8'h0;
    end
    nxt_st.pwc_ctl = ~(nxt_st.pwc_busy ^ nxt_st.pwc_pol);

    // a new event beats a clear in the same cycle
    nxt_st.stat = (st_ff.stat & ~stat_clr) | stat_set;
    nxt_st.irq = |(nxt_st.stat & nxt_st.imsk);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= TOP_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register
  assign s_axil_awready_o = st_ff.awrdy;
  assign s_axil_wready_o = st_ff.wrdy;
  assign s_axil_bvalid_o = st_ff.bvalid;
  assign s_axil_bresp_o = st_ff.bresp;
  assign s_axil_arready_o = st_ff.arrdy;
  assign s_axil_rvalid_o = st_ff.rvalid;
  assign s_axil_rdata_o = st_ff.rdata;
  assign s_axil_rresp_o = st_ff.rresp;
  assign irq_o = st_ff.irq;
  assign alarm_pulse_o = st_ff.pulse;
  assign pwc_ctl_o = st_ff.pwc_ctl;
  assign pwc_sample_o = st_ff.sample;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  window_lock_a: assert property (
    (wr_do && st_ff.aw_addr == `RC_OFF_PWIN && !st_ff.unlock) |=> $stable(st_ff.pwin))
    else $error("window written while locked");
  window_len_a: assert property (
    $rose(st_ff.sample) |-> $past(st_ff.pwc_cnt) == $past(st_ff.pwin)
      && $past(st_ff.pwc_busy))
    else $error("stability window length wrong");
  last_alarm_a: assert property (
    (al_ev && st_ff.rpt == 8'h0 && !st_ff.endless) |=> !st_ff.al_on)
    else $error("alarm on not cleared after last alarm");
  repeat_dec_a: assert property (
    (al_ev && st_ff.rpt != 8'h0) |=> st_ff.al_on && st_ff.rpt == $past(st_ff.rpt) - 8'h1)
    else $error("repeat count not decremented");
  endless_wrap_a: assert property (
    (al_ev && st_ff.rpt == 8'h0 && st_ff.endless) |=> st_ff.al_on && st_ff.rpt == 8'hff)
    else $error("endless repeat did not wrap");
  alarm_irq_a: assert property (
    al_ev |=> st_ff.stat[0] && (!st_ff.imsk[0] || irq_o))
    else $error("alarm did not raise interrupt");
  pulse_toggle_a: assert property (
    al_ev |=> alarm_pulse_o != $past(alarm_pulse_o))
    else $error("alarm pulse did not toggle");
  pulse_hold_a: assert property (
    !al_ev |=> $stable(alarm_pulse_o))
    else $error("alarm pulse moved without alarm");
  pwc_start_a: assert property (
    (al_ev && st_ff.pwc_en && !st_ff.pwc_busy) |=> st_ff.pwc_busy
      && pwc_ctl_o == st_ff.pwc_pol)
    else $error("power control not started by alarm");
  alarm_off_a: assert property (
    (!st_ff.al_on && !wr_do) |=> !st_ff.al_on)
    else $error("alarm turned on without a write");
endmodule // rtcca_top

// [core/rtcca_cfg.svh]
// offsets, field positions, reset values and timing counts of the rtc alarm block
`ifndef RTCCA_CFG_SVH
`define RTCCA_CFG_SVH
// register byte offsets
`define RC_OFF_CTRL 8'h00
`define RC_OFF_CAL 8'h04
`define RC_OFF_ALCFG 8'h08
`define RC_OFF_ALV_LO 8'h0c
`define RC_OFF_ALV_HI 8'h10
`define RC_OFF_PWIN 8'h14
`define RC_OFF_STAT 8'h18
`define RC_OFF_IMSK 8'h1c
`define RC_OFF_STATE 8'h20
// alarm config field positions
`define RC_AL_ON 15
`define RC_AL_ENDLESS 14
`define RC_AL_MASK_HI 13
`define RC_AL_MASK_LO 10
`define RC_AL_MASK_MAX 4'h9
// reset and wrap values
`define RC_PWIN_RST 8'hff
`define RC_RPT_WRAP 8'hff
// axi answers
`define RC_RESP_OK 2'h0
`define RC_RESP_ERR 2'h2
// timing
`define RC_CLK_HZ 25000000
`define RC_TICK_HZ 32768
`define RC_TICK_CYC (`RC_CLK_HZ / `RC_TICK_HZ)
`define RC_CAL_SHIFT 2
`define RC_SEC_LAST 6'h3b
`define RC_SYNC_FROM 15'h7fe0
`endif

// [core/rtcca_pkg.sv]
// state types of the rtc calibration and alarm block
package rtcca_pkg;
  // timebase state
  typedef struct packed {
    logic [9:0] div;
    logic tick;
    logic [14:0] sub;
    logic half;
    logic sec;
    logic [5:0] secs;
    logic [9:0] adj;
    logic neg;
    logic sync;
  } rtcca_tb_s;
  // alarm match state
  typedef struct packed {
    logic sec_d;
    logic half_d;
    logic ev;
  } rtcca_am_s;
  // top state: bus slave, registers, alarm and power control
  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awrdy;
    logic wrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic unlock;
    logic run;
    logic pwc_en;
    logic pwc_pol;
    logic [7:0] cal;
    logic al_on;
    logic endless;
    logic [3:0] alarm_digit_mask;
    logic [7:0] rpt;
    logic [23:0] alv_lo;
    logic [23:0] alv_hi;
    logic [7:0] pwin;
    logic [1:0] stat;
    logic [1:0] imsk;
    logic pulse;
    logic irq;
    logic pwc_busy;
    logic [7:0] pwc_cnt;
    logic pwc_ctl;
    logic sample;
  } rtcca_top_s;
endpackage

// [core/rtcca_link_if.sv]
// signals shared by the top, the timebase and the alarm matcher
`timescale 1ns/1ps
interface rtcca_link_if;
  logic run;
  logic [7:0] cal;
  logic tick;
  logic sec_pulse;
  logic half_pulse;
  logic sync;
  logic [47:0] now;
  logic [47:0] alv;
  logic [3:0] alarm_digit_mask;
  logic ev;
  modport tb (input run, cal, output tick, sec_pulse, half_pulse, sync);
  modport am (input sec_pulse, half_pulse, now, alv, alarm_digit_mask, output ev);
  modport top (output run, cal, now, alv, alarm_digit_mask,
               input tick, sec_pulse, half_pulse, sync, ev);
endinterface

// [core/rtcca_timebase.sv]
// rtc timebase: tick divider, subsecond count, per-minute calibration
`timescale 1ns/1ps
`include "rtcca_cfg.svh"
module rtcca_timebase import rtcca_pkg::*; #(
  parameter int unsigned TICK_CYC = `RC_TICK_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  rtcca_link_if.tb lnk
);
  rtcca_tb_s st_ff;
  rtcca_tb_s nxt_st;
  logic [8:0] mag;
  logic [9:0] cal_pulses;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    // magnitude of the signed value, scaled by four
    mag = lnk.cal[7] ? (9'h100 - {1'b0, lnk.cal}) : {1'b0, lnk.cal};
    cal_pulses = {1'b0, mag} << `RC_CAL_SHIFT;
    if (!lnk.run) begin
      nxt_st.div = '0;
    end else if (st_ff.div == 10'(TICK_CYC - 1)) begin
      nxt_st.div = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.div = st_ff.div + 10'h1;
    end
    // a fast crystal loses pulses, a slow one gains them
    if (st_ff.tick) begin
      if (st_ff.adj != '0 && st_ff.neg) begin
        nxt_st.adj = st_ff.adj - 10'h1;
      end else if (st_ff.adj != '0) begin
        nxt_st.adj = st_ff.adj - 10'h1;
        nxt_st.sub = st_ff.sub + 15'h2;
      end else begin
        nxt_st.sub = st_ff.sub + 15'h1;
      end
    end
    // bit 14 flips at each half second; its fall is the second
    nxt_st.half = nxt_st.sub[14] != st_ff.sub[14];
    nxt_st.sec = st_ff.sub[14] & ~nxt_st.sub[14];
    if (nxt_st.sec) begin
      if (st_ff.secs == `RC_SEC_LAST) begin
        nxt_st.secs = '0;
        nxt_st.adj = cal_pulses;
        nxt_st.neg = lnk.cal[7];
      end else begin
        nxt_st.secs = st_ff.secs + 6'h1;
      end
    end
    nxt_st.sync = lnk.run && nxt_st.sub >= `RC_SYNC_FROM;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lnk.tick = st_ff.tick;
  assign lnk.sec_pulse = st_ff.sec;
  assign lnk.half_pulse = st_ff.half;
  assign lnk.sync = st_ff.sync;

  ////////////////////////////////////////////////////////////////////////
  // checks
  cal_load_a: assert property (
    (st_ff.sec && st_ff.secs == 6'h0 && $past(st_ff.secs) == `RC_SEC_LAST)
    |-> st_ff.adj == ({1'b0, $past(mag)} << 2) && st_ff.neg == $past(lnk.cal[7]))
    else $error("calibration not loaded at minute");
  cal_swallow_a: assert property (
    (st_ff.tick && st_ff.adj != '0 && st_ff.neg) |=> $stable(st_ff.sub))
    else $error("negative correction did not drop a pulse");
  cal_extra_a: assert property (
    (st_ff.tick && st_ff.adj != '0 && !st_ff.neg && !nxt_st.sec)
    |=> st_ff.sub == $past(st_ff.sub) + 15'h2)
    else $error("positive correction did not add a pulse");
endmodule // rtcca_timebase

// [core/rtcca_match.sv]
// alarm matcher: masked compare of calendar digits on each half/whole second
`timescale 1ns/1ps
`include "rtcca_cfg.svh"
module rtcca_match import rtcca_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  rtcca_link_if.am lnk
);
  rtcca_am_s st_ff;
  rtcca_am_s nxt_st;
  logic hit;

  // digit bytes are {wday, month, day, hour, minute, second}
  function automatic logic [47:0] digit_sel(input logic [3:0] m);
    case (m)
      4'h2: digit_sel = 48'h0000_0000_000f;
      4'h3: digit_sel = 48'h0000_0000_00ff;
      4'h4: digit_sel = 48'h0000_0000_0fff;
      4'h5: digit_sel = 48'h0000_0000_ffff;
      4'h6: digit_sel = 48'h0000_00ff_ffff;
      4'h7: digit_sel = 48'hff00_00ff_ffff;
      4'h8: digit_sel = 48'h0000_ffff_ffff;
      4'h9: digit_sel = 48'h00ff_ffff_ffff;
      default: digit_sel = 48'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // compare one cycle after the pulse, once the calendar has stepped
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sec_d = lnk.sec_pulse;
    nxt_st.half_d = lnk.half_pulse;
    // yearly mode compares month and day exactly, so a leap-day alarm
    // only fires in years that have that date
    hit = ((lnk.now ^ lnk.alv) & digit_sel(lnk.alarm_digit_mask)) == 48'h0;
    nxt_st.ev = hit && lnk.alarm_digit_mask <= `RC_AL_MASK_MAX
      && (lnk.alarm_digit_mask == 4'h0 ? st_ff.half_d : st_ff.sec_d);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lnk.ev = st_ff.ev;

  mask_code_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (lnk.alarm_digit_mask > `RC_AL_MASK_MAX || (!st_ff.sec_d && lnk.alarm_digit_mask != 4'h0)) |=> !st_ff.ev)
    else $error("alarm event outside its interval");
endmodule // rtcca_match

// [dv/rtc_calibration_and_alarm_tb.sv]
// self-checking bench for the rtc calibration and alarm block over axi4-lite
`timescale 1ns/1ps
`include "rtcca_cfg.svh"
module rtc_calibration_and_alarm_tb import rtcca_pkg::*;;
  // one tick per clock keeps a half second at 16384 cycles
  localparam int unsigned TICK = 1;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, apulse, pwc_ctl, pwc_smp;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic [1:0] rs;
  int num_errors = 0;
  int n_compared = 0;

  ////////////////////////////////////////////////////////////////////////////////
  rtcca_top #(.TICK_CYC(TICK)) dut_u (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .s_axil_awaddr_i(awaddr), .s_axil_awvalid_i(awvalid), .s_axil_awready_o(awready),
    .s_axil_wdata_i(wdata), .s_axil_wstrb_i(wstrb), .s_axil_wvalid_i(wvalid),
    .s_axil_wready_o(wready), .s_axil_bresp_o(bresp), .s_axil_bvalid_o(bvalid),
    .s_axil_bready_i(bready), .s_axil_araddr_i(araddr), .s_axil_arvalid_i(arvalid),
    .s_axil_arready_o(arready), .s_axil_rdata_o(rdata), .s_axil_rresp_o(rresp),
    .s_axil_rvalid_o(rvalid), .s_axil_rready_i(rready),
    .time_now_i(48'h0), .irq_o(irq), .alarm_pulse_o(apulse),
    .pwc_ctl_o(pwc_ctl), .pwc_sample_o(pwc_smp)
  );

  // 25 mhz clock
  always #20 ref_clk_i = ~ref_clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad;
    logic wd;
    int n;
    ad = 1'b0;
    wd = 1'b0;
    n = 0;
    @(posedge ref_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd) && n < 1000) begin
      @(posedge ref_clk_i);
      n++;
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (bvalid !== 1'b1 && n < 2000);
    // a write that never completes counts against the run
    if (bvalid !== 1'b1) begin
      num_errors++;
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (arready !== 1'b1 && n < 1000);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (rvalid !== 1'b1 && n < 2000);
    if (rvalid !== 1'b1) begin
      num_errors++;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, rs);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    axi_rd(a, rd, rs);
    chk(rd, exp, what);
  endtask

  // waits for the alarm output to reach a level, bounded by 40000 ticks, a little over one second
  task automatic wait_pulse(input logic v);
    int n;
    n = 0;
    while (apulse !== v && n < 40000) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk({31'h0, apulse}, {31'h0, v}, "alarm pulse level");
    repeat (3) @(posedge ref_clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog sized above the three half-second waits and the quiet span
  initial begin
    repeat (95000) @(posedge ref_clk_i);
    num_errors++;
    close_out();
  end

  // main sequence
  initial begin
    int n;
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd_chk(`RC_OFF_CTRL, 32'h8, "ctrl reset");
    rd_chk(`RC_OFF_PWIN, 32'hff, "window reset");
    rd_chk(`RC_OFF_ALCFG, 32'h0, "alarm cfg reset");
    axi_rd(8'h24, rd, rs);
    chk({30'h0, rs}, {30'h0, `RC_RESP_ERR}, "unmapped read resp");
    chk(rd, 32'h0, "unmapped read data");
    axi_wr(8'h28, 32'h1, rs);
    chk({30'h0, rs}, {30'h0, `RC_RESP_ERR}, "unmapped write resp");
    // window is locked until the write unlock bit is set
    wr(`RC_OFF_PWIN, 32'h10);
    rd_chk(`RC_OFF_PWIN, 32'hff, "locked window write");
    wr(`RC_OFF_CTRL, 32'h9);
    // long enough a window to watch the control output while it is active
    wr(`RC_OFF_PWIN, 32'h40);
    rd_chk(`RC_OFF_PWIN, 32'h40, "unlocked window write");
    wr(`RC_OFF_CAL, 32'hfc);
    rd_chk(`RC_OFF_CAL, 32'hfc, "calibration value");
    // unstrobed byte lanes keep their value
    wstrb <= 4'he;
    wr(`RC_OFF_CAL, 32'h0);
    wstrb <= 4'hf;
    rd_chk(`RC_OFF_CAL, 32'hfc, "unstrobed lane kept");
    wr(`RC_OFF_ALV_LO, 32'h0);
    // half-second alarm with one repeat: two alarms, then off
    wr(`RC_OFF_IMSK, 32'h1);
    wr(`RC_OFF_ALCFG, 32'h8001);
    wr(`RC_OFF_CTRL, 32'hb);
    wait_pulse(1'b1);
    chk({31'h0, irq}, 32'h1, "irq on first alarm");
    rd_chk(`RC_OFF_STAT, 32'h1, "alarm status set");
    rd_chk(`RC_OFF_ALCFG, 32'h8000, "count decremented");
    wr(`RC_OFF_STAT, 32'h1);
    rd_chk(`RC_OFF_STAT, 32'h0, "alarm status cleared");
    chk({31'h0, irq}, 32'h0, "irq after clear");
    wait_pulse(1'b0);
    chk({31'h0, irq}, 32'h1, "irq on last alarm");
    rd_chk(`RC_OFF_ALCFG, 32'h0, "alarm on cleared");
    wr(`RC_OFF_STAT, 32'h1);
    repeat (20000) @(posedge ref_clk_i);
    rd_chk(`RC_OFF_STAT, 32'h0, "no alarm after last");
    // endless repeat with power control, interrupt masked out
    wr(`RC_OFF_IMSK, 32'h0);
    wr(`RC_OFF_CTRL, 32'hf);
    wr(`RC_OFF_ALCFG, 32'hc000);
    wait_pulse(1'b1);
    chk({31'h0, irq}, 32'h0, "masked irq stays low");
    n = 0;
    while (pwc_smp !== 1'b1 && n < 200) begin
      chk({31'h0, pwc_ctl}, 32'h1, "power control active");
      @(posedge ref_clk_i);
      n++;
    end
    chk({31'h0, pwc_smp}, 32'h1, "window sample pulse");
    repeat (3) @(posedge ref_clk_i);
    chk({31'h0, pwc_ctl}, 32'h0, "power control idle");
    rd_chk(`RC_OFF_ALCFG, 32'hc0ff, "count wraps");
    rd_chk(`RC_OFF_STAT, 32'h3, "window done status");
    wr(`RC_OFF_IMSK, 32'h3);
    repeat (3) @(posedge ref_clk_i);
    chk({31'h0, irq}, 32'h1, "irq after unmask");
    close_out();
  end
endmodule // rtc_calibration_and_alarm_tb
